// File: design/mbls_top.sv
// Byte-lane steering between core data and the 32-bit external memory bus.
// Assumes straps are held steady during reset and that requests are synchronous to clock_i.
`timescale 1ns/100ps
module mbls_top (
  input  wire logic                  clock_i,
  input  wire logic                  rst_i,
  input  wire logic                  ext_reset_n_i,
  input  wire logic                  endian_select_strap_i,
  input  wire logic                  lane_correction_strap_i,
  input  wire logic [1:0]            mem_width_i,
  input  wire mbls_pkg::mbls_req_s   req_i,
  output logic                       running_o,
  output logic                       little_endian_select_o,
  output logic                       big_endian_correction_o,
  output mbls_pkg::mbls_bus_s        bus_o
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  // Every register of the block lives in this one struct.
  typedef struct packed {
    mbls_pkg::mbls_phase_e phase;
    logic                  running;
    logic                  little;
    logic                  corr_on;
    mbls_pkg::mbls_bus_s   bus;
  } mbls_state_s;

  mbls_state_s st;
  mbls_state_s next_st;

  // Reset state shared by both resets, so a device reset clears the same bits.
  localparam mbls_state_s ST_RESET = '{
    phase:   mbls_pkg::MBLS_RESET,
    running: 1'b0,
    little:  mbls_pkg::ENDIAN_DEFAULT,
    corr_on: ~mbls_pkg::CORR_DEFAULT,
    bus:     '{valid:   1'b0,
               lane_en: mbls_pkg::LANES_RESET,
               data:    mbls_pkg::DATA_RESET}
  };

  // The interface clock here is far below the limit; this guards a retarget.
  localparam int unsigned CLK_OK =
    (mbls_pkg::CLOCK_MHZ <= mbls_pkg::IFACE_MAX_MHZ) ? 1 : 0;

  // Lane offset of the first byte: corrected or little puts it low.
  function automatic logic [1:0] base_lane(input mbls_pkg::mbls_width_e w,
                                           input logic                  little,
                                           input logic                  corr_on);
    if (w == mbls_pkg::MBLS_W32 || little || corr_on) begin
      base_lane = 2'h0;
    end else if (w == mbls_pkg::MBLS_W16) begin
      base_lane = mbls_pkg::BASE_HALF_BIG;
    end else begin
      base_lane = mbls_pkg::BASE_BYTE_BIG;
    end
  endfunction : base_lane

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  // Straps are caught in a clocked phase after release, never by the async reset.
  always_comb begin
    mbls_pkg::mbls_width_e w;
    logic [1:0]            base;
    w       = mbls_pkg::mbls_width_e'(mem_width_i);
    base    = 2'h0;
    next_st = st;
    next_st.bus.valid = 1'b0;
    case (st.phase)
      mbls_pkg::MBLS_RESET: begin
        next_st.bus.lane_en = mbls_pkg::LANES_RESET;
        next_st.bus.data    = mbls_pkg::DATA_RESET;
        if (ext_reset_n_i) begin
          next_st.phase = mbls_pkg::MBLS_LATCH;
        end
      end
      mbls_pkg::MBLS_LATCH: begin
        next_st.little  = endian_select_strap_i;
        next_st.corr_on = ~lane_correction_strap_i;
        next_st.phase   = mbls_pkg::MBLS_RUN;
      end
      mbls_pkg::MBLS_RUN: begin
        // Width code 3 has no memory of its own and takes the byte path.
        if (req_i.valid && CLK_OK == 1) begin
          base = base_lane(w, st.little, st.corr_on);
          if (w == mbls_pkg::MBLS_W32) begin
            next_st.bus.lane_en = mbls_pkg::LANE_ALL;
            next_st.bus.data    = req_i.data;
          end else if (w == mbls_pkg::MBLS_W16) begin
            next_st.bus.lane_en = mbls_pkg::LANE_HALF << base;
            next_st.bus.data    = {16'h0000, req_i.data[15:0]} << {base, 3'h0};
          end else begin
            next_st.bus.lane_en = mbls_pkg::LANE_BYTE << base;
            next_st.bus.data    = {24'h00_0000, req_i.data[7:0]} << {base, 3'h0};
          end
          next_st.bus.valid = 1'b1;
        end
      end
      default: begin
        next_st.phase = mbls_pkg::MBLS_RESET;
      end
    endcase
    // External reset low puts every bit back to its reset value, mode included.
    if (!ext_reset_n_i) begin
      next_st = ST_RESET;
    end
    // A register of its own, so running_o needs no decoder behind the flop.
    next_st.running = (next_st.phase == mbls_pkg::MBLS_RUN);
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  // Constants only under reset; the power-on strap defaults seed the mode.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      st <= ST_RESET;
    end else begin
      st <= next_st;
    end
  end

  // Outputs are plain flip-flop copies so they stay glitch free toward the pads.
  assign running_o               = st.running;
  assign little_endian_select_o  = st.little;
  assign big_endian_correction_o = st.corr_on;
  assign bus_o                   = st.bus;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  // Reset, release and acceptance. A request counts as taken only when the
  // block is running and the external reset is high on the same edge.
  a_reset_hold: assert property (@(posedge clock_i) disable iff (rst_i)
    !ext_reset_n_i |=> !running_o && !bus_o.valid)
    else $error("output active while external reset low");

  a_reset_state: assert property (@(posedge clock_i) disable iff (rst_i)
    !ext_reset_n_i |=> bus_o.lane_en == mbls_pkg::LANES_RESET
    && little_endian_select_o == mbls_pkg::ENDIAN_DEFAULT && !big_endian_correction_o)
    else $error("state not cleared while external reset low");

  a_no_spurious: assert property (@(posedge clock_i) disable iff (rst_i)
    !(running_o && req_i.valid && ext_reset_n_i) |=> !bus_o.valid)
    else $error("bus valid without a taken request");

  a_release_run: assert property (@(posedge clock_i) disable iff (rst_i)
    !ext_reset_n_i ##1 ext_reset_n_i [*2] |=> running_o)
    else $error("not running after release");

  a_req_answered: assert property (@(posedge clock_i) disable iff (rst_i)
    running_o && req_i.valid && ext_reset_n_i |=> bus_o.valid)
    else $error("taken request not answered");

  a_mode_steady: assert property (@(posedge clock_i) disable iff (rst_i)
    running_o && $past(running_o)
    |-> $stable(little_endian_select_o) && $stable(big_endian_correction_o))
    else $error("mode changed while running");

  a_strap_latch: assert property (@(posedge clock_i) disable iff (rst_i)
    $rose(running_o) |-> little_endian_select_o == $past(endian_select_strap_i)
    && big_endian_correction_o == !$past(lane_correction_strap_i))
    else $error("strap not captured at release");

  // Lane steering per width and mode. Unused lanes must carry zero so that a
  // narrow memory never sees stale data on lanes it does not decode.
  a_wide_lanes: assert property (@(posedge clock_i) disable iff (rst_i)
    running_o && req_i.valid && ext_reset_n_i && mem_width_i == mbls_pkg::MBLS_W32
    |=> bus_o.lane_en == mbls_pkg::LANE_ALL && bus_o.data == $past(req_i.data))
    else $error("wide access not on all lanes");

  a_little_byte: assert property (@(posedge clock_i) disable iff (rst_i)
    running_o && little_endian_select_o && req_i.valid && ext_reset_n_i
    && mem_width_i == mbls_pkg::MBLS_W8
    |=> bus_o.lane_en == 4'h1 && bus_o.data[7:0] == $past(req_i.data[7:0]))
    else $error("little byte not on lane 0");

  a_byte_upper_zero: assert property (@(posedge clock_i) disable iff (rst_i)
    running_o && little_endian_select_o && req_i.valid && ext_reset_n_i
    && mem_width_i == mbls_pkg::MBLS_W8 |=> bus_o.data[31:8] == 24'h00_0000)
    else $error("little byte leaves data on upper lanes");

  a_big_byte: assert property (@(posedge clock_i) disable iff (rst_i)
    running_o && !little_endian_select_o && !big_endian_correction_o && req_i.valid
    && ext_reset_n_i && mem_width_i == mbls_pkg::MBLS_W8
    |=> bus_o.lane_en == 4'h8 && bus_o.data[31:24] == $past(req_i.data[7:0]))
    else $error("big byte not on lane 3");

  a_big_lower_zero: assert property (@(posedge clock_i) disable iff (rst_i)
    running_o && !little_endian_select_o && !big_endian_correction_o && req_i.valid
    && ext_reset_n_i && mem_width_i == mbls_pkg::MBLS_W8 |=> bus_o.data[23:0] == 24'h00_0000)
    else $error("big byte leaves data on lower lanes");

  a_corr_low: assert property (@(posedge clock_i) disable iff (rst_i)
    running_o && big_endian_correction_o && req_i.valid && ext_reset_n_i
    && mem_width_i == mbls_pkg::MBLS_W8
    |=> bus_o.lane_en == 4'h1 && bus_o.data[7:0] == $past(req_i.data[7:0]))
    else $error("corrected byte not on lane 0");

  a_little_half: assert property (@(posedge clock_i) disable iff (rst_i)
    running_o && little_endian_select_o && req_i.valid && ext_reset_n_i
    && mem_width_i == mbls_pkg::MBLS_W16
    |=> bus_o.lane_en == 4'h3 && bus_o.data[15:0] == $past(req_i.data[15:0]))
    else $error("little halfword not on lower lanes");

  a_big_half: assert property (@(posedge clock_i) disable iff (rst_i)
    running_o && !little_endian_select_o && !big_endian_correction_o && req_i.valid
    && ext_reset_n_i && mem_width_i == mbls_pkg::MBLS_W16
    |=> bus_o.lane_en == 4'hC && bus_o.data[31:16] == $past(req_i.data[15:0]))
    else $error("big halfword not on upper lanes");

  a_corr_half: assert property (@(posedge clock_i) disable iff (rst_i)
    running_o && big_endian_correction_o && req_i.valid && ext_reset_n_i
    && mem_width_i == mbls_pkg::MBLS_W16
    |=> bus_o.lane_en == 4'h3 && bus_o.data[15:0] == $past(req_i.data[15:0])
    && bus_o.data[31:16] == 16'h0000)
    else $error("corrected halfword not on lower lanes");

endmodule : mbls_top

// File: design/mbls_pkg.sv
// Package for the memory bus byte-lane steering block: widths, strap defaults, modes.
// Assumes a 32-bit external data bus split into four byte lanes.
package mbls_pkg;

  // ----------------------------------------------------------------------
  // Sizes and defaults
  // ----------------------------------------------------------------------
  localparam int          DATA_W          = 32;
  localparam int          LANES           = 4;
  localparam logic        ENDIAN_DEFAULT  = 1'b1;   // One selects little endian.
  localparam logic        CORR_DEFAULT    = 1'b1;   // One leaves correction disabled.
  localparam int          IFACE_MAX_MHZ   = 100;
  localparam int          CLOCK_MHZ       = 25;
  localparam logic [3:0]  LANES_RESET     = 4'h0;
  localparam logic [31:0] DATA_RESET      = 32'h0000_0000;
  localparam logic [3:0]  LANE_ALL        = 4'hF;   // Wide memory drives every lane.
  localparam logic [3:0]  LANE_HALF       = 4'h3;   // Halfword lanes before steering.
  localparam logic [3:0]  LANE_BYTE       = 4'h1;   // Byte lane before steering.
  localparam logic [1:0]  BASE_HALF_BIG   = 2'h2;   // First lane of an uncorrected big halfword.
  localparam logic [1:0]  BASE_BYTE_BIG   = 2'h3;   // Lane of an uncorrected big byte.

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    MBLS_W8,
    MBLS_W16,
    MBLS_W32
  } mbls_width_e;

  typedef enum logic [1:0] {
    MBLS_RESET,
    MBLS_LATCH,
    MBLS_RUN
  } mbls_phase_e;

  // Request from the core side for one transfer.
  typedef struct packed {
    logic        valid;
    logic [1:0]  byte_addr;
    logic [31:0] data;
  } mbls_req_s;

  // Steered output toward the external bus.
  typedef struct packed {
    logic        valid;
    logic [3:0]  lane_en;
    logic [31:0] data;
  } mbls_bus_s;

endpackage : mbls_pkg

// File: verification/mbls_mem_model.sv
// External memory model standing on the far side of the steered data bus.
// Assumes bus_i is synchronous to clock_i; only enabled byte lanes are written.
`timescale 1ns/100ps
module mbls_mem_model (
  input  wire logic                clock_i,
  input  wire mbls_pkg::mbls_bus_s bus_i,
  output logic [31:0]              word_o
);
  // Each enabled lane stores its byte; disabled lanes keep the old contents.
  always_ff @(posedge clock_i) begin
    for (int i = 0; i < mbls_pkg::LANES; i++) begin
      if (bus_i.valid && bus_i.lane_en[i]) begin
        word_o[i*8 +: 8] <= bus_i.data[i*8 +: 8];
      end
    end
  end
endmodule : mbls_mem_model

// File: verification/memory_bus_byte_lane_steering_test.sv
// Self-checking bench for the byte-lane steering block.
// Assumes straps are held steady by the bench through each device reset.
`timescale 1ns/100ps
module memory_bus_byte_lane_steering_test;
  logic                clock_i, rst_i, ext_reset_n_i, endian_i, corr_i, running, le_o, bc_o;
  logic [1:0]          mem_width_i;
  logic [31:0]         word;
  mbls_pkg::mbls_req_s req_i;
  mbls_pkg::mbls_bus_s bus;
  int                  miscompares, tests_run, cycles;

  mbls_top i_dut (.clock_i(clock_i), .rst_i(rst_i), .ext_reset_n_i(ext_reset_n_i),
    .endian_select_strap_i(endian_i), .lane_correction_strap_i(corr_i),
    .mem_width_i(mem_width_i), .req_i(req_i), .running_o(running),
    .little_endian_select_o(le_o), .big_endian_correction_o(bc_o), .bus_o(bus));
  mbls_mem_model i_mem (.clock_i(clock_i), .bus_i(bus), .word_o(word));

  // Clock of 40 ns, well below the interface limit.
  initial begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end

  task automatic check(input logic [36:0] seen, input logic [36:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test

  // Expected bus word: narrow data from lane 0 up unless big endian without correction.
  function automatic logic [36:0] exp_bus(input logic [1:0] w, input logic le, input logic co,
                                         input logic [31:0] d);
    logic [3:0]  ln;
    logic [31:0] q;
    ln = (w == 2'h1) ? 4'h3 : 4'h1;
    q  = (w == 2'h1) ? {16'h0000, d[15:0]} : {24'h00_0000, d[7:0]};
    if (w == 2'h2) begin
      ln = 4'hF;
      q  = d;
    end else if (!le && co) begin
      ln = (w == 2'h1) ? 4'hC : 4'h8;
      q  = (w == 2'h1) ? (q << 16) : (q << 24);
    end
    return {1'b1, ln, q};
  endfunction : exp_bus

  // One request, answered at the edge that takes it and checked 1 ns later.
  task automatic xfer(input logic [1:0] w, input logic le, input logic co, input logic [31:0] d);
    mem_width_i = w;
    req_i       = {1'b1, 2'h0, d};
    @(posedge clock_i);
    #1;
    check(bus, exp_bus(w, le, co, d));
  endtask : xfer

  // Device reset with given straps, refused traffic, release, then all widths back to back.
  task automatic run_cfg(input logic le, input logic co);
    int n;
    endian_i      = le;
    corr_i        = co;
    ext_reset_n_i = 1'b0;
    req_i         = {1'b1, 2'h0, 32'hDEAD_BEEF};
    repeat (3) @(posedge clock_i);
    #1;
    check({running, bus.valid}, 37'h0);
    ext_reset_n_i = 1'b1;
    req_i.valid   = 1'b0;
    // Poll off the edge so the flop update is already visible.
    for (n = 0; n < 8 && running !== 1'b1; n++) begin
      @(posedge clock_i);
      #1;
    end
    check({running, le_o, bc_o}, {1'b1, le, ~co});
    xfer(2'h0, le, co, 32'h1234_56A5);
    xfer(2'h1, le, co, 32'h89AB_C3D7);
    xfer(2'h3, le, co, 32'h7E51_0C69);
    xfer(2'h2, le, co, 32'hF00D_4B1E);
    req_i.valid = 1'b0;
    @(posedge clock_i);
    #1;
    check(bus.valid, 37'h0);
    check(word, 37'hF00D_4B1E);
  endtask : run_cfg

  // Runaway guard well above the expected run length.
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      finish_test();
    end
  end

  initial begin
    {miscompares, tests_run, cycles} = '0;
    {rst_i, ext_reset_n_i, endian_i, corr_i} = 4'hF;
    mem_width_i = 2'h0;
    req_i       = '0;
    repeat (16) @(posedge clock_i);
    #1;
    rst_i = 1'b0;
    check({running, le_o, bc_o}, 37'h2);
    run_cfg(1'b1, 1'b1);
    run_cfg(1'b0, 1'b1);
    run_cfg(1'b0, 1'b0);
    run_cfg(1'b1, 1'b0);
    finish_test();
  end
endmodule : memory_bus_byte_lane_steering_test
